// ---- rtl/ssf_pkg.sv ----
// constants, state types and helpers of the sample status flag block
package ssf_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PERIOD_W = 24;
   localparam int IRQ_W = 4;

   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_MAIN_CONTROL = 8'h10;
   localparam logic [7:0] IDX_STATUS = 8'h27;
   localparam logic [7:0] IDX_PRESS_HIGH = 8'h2A;
   localparam logic [7:0] IDX_TEMP_HIGH = 8'h2C;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
   localparam logic [7:0] IDX_RATE_PERIOD = 8'h32;

   // status register field positions
   localparam int STAT_PRESS_READY_BIT = 0;
   localparam int STAT_TEMP_READY_BIT = 1;
   localparam int STAT_PRESS_OVR_BIT = 4;
   localparam int STAT_TEMP_OVR_BIT = 5;

   // interrupt status and mask field positions
   localparam int IRQ_PRESS_READY_BIT = 0;
   localparam int IRQ_TEMP_READY_BIT = 1;
   localparam int IRQ_PRESS_OVR_BIT = 2;
   localparam int IRQ_TEMP_OVR_BIT = 3;

   // main control field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;

   // values after reset
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic CTRL_RUN_RST = 1'h1;
   localparam logic CTRL_HOLD_RST = 1'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   localparam logic [PERIOD_W-1:0] RATE_PERIOD_RST = 24'h0003E8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [PERIOD_W-1:0] cnt;
      logic tick;
   } ssf_div_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] awaddr;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic ctrl_run;
      logic block_update_hold;
      logic [PERIOD_W-1:0] rate_period;
      logic press_ready_flag;
      logic temp_ready_flag;
      logic press_ovr;
      logic temp_ovr;
      logic press_pend;
      logic temp_pend;
      logic [7:0] press_pend_high;
      logic [7:0] temp_pend_high;
      logic [7:0] press_result_high;
      logic [7:0] temp_result_high;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
   } ssf_state_t;

   function automatic logic ssf_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
      ssf_hit = (addr == {2'h0, idx, 2'h0});
   endfunction : ssf_hit

endpackage : ssf_pkg

// ---- rtl/ssf_rate_div.sv ----
// output rate divider: one-cycle pulse every programmed number of cycles
`timescale 1ns/10ps
module ssf_rate_div import ssf_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [PERIOD_W-1:0] period,
   output logic tick
);

   ssf_div_t st_ff;
   ssf_div_t nxt_st;
   logic [PERIOD_W-1:0] last;

   always_comb begin
      // a period of zero behaves as one
      last = (period == '0) ? '0 : period - 24'h000001;
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!run) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt >= last) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 24'h000001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

endmodule : ssf_rate_div

// ---- rtl/ssf_status.sv ----
// sample status flags with an AXI4-Lite register slave
//
// Operation
// RULE1 - flags are refreshed on every output rate cycle, ignoring update hold
// RULE2 - temperature overrun bit 5 sets when new data finds ready still set
// RULE3 - reading temperature high byte at 0x2C clears temperature overrun
// RULE4 - pressure overrun bit 4 sets likewise; pressure high read clears it
// RULE5 - fresh temperature sample sets ready; temperature high read clears it
// RULE6 - fresh pressure sample sets ready; pressure high read clears it
// RULE7 - temperature ready sits at status bit 1, zero after reset
// RULE8 - pressure ready sits at status bit 0, zero after reset
// RULE9 - reserved status bits read zero; writes to status are ignored
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ssf_status import ssf_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic press_sample_valid,
   input wire logic [7:0] press_sample_high,
   input wire logic temp_sample_valid,
   input wire logic [7:0] temp_sample_high,
   output logic irq
);

   ssf_state_t st_ff;
   ssf_state_t nxt_st;

   logic output_rate_cycle;
   logic rd_fire;
   logic wr_fire;
   logic rd_press;
   logic rd_temp;
   logic rd_irq;
   logic press_commit;
   logic temp_commit;
   logic press_ovr_set;
   logic temp_ovr_set;
   logic [7:0] status_view;
   logic [DATA_W-1:0] rd_data;
   logic [1:0] rd_resp;
   logic [IRQ_W-1:0] irq_events;

   ssf_rate_div u_rate_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(st_ff.ctrl_run),
      .period(st_ff.rate_period),
      .tick(output_rate_cycle)
   );

   // status byte as software sees it; reserved bits stay zero
   always_comb begin
      status_view = STATUS_RST; // RULE9
      status_view[STAT_PRESS_READY_BIT] = st_ff.press_ready_flag; // RULE8
      status_view[STAT_TEMP_READY_BIT] = st_ff.temp_ready_flag; // RULE7
      status_view[STAT_PRESS_OVR_BIT] = st_ff.press_ovr; // RULE4
      status_view[STAT_TEMP_OVR_BIT] = st_ff.temp_ovr; // RULE2
   end

   // read decode for the address offered on the read channel
   always_comb begin
      rd_data = '0;
      rd_resp = RESP_OKAY;
      rd_press = 1'b0;
      rd_temp = 1'b0;
      rd_irq = 1'b0;
      rd_fire = st_ff.arready & s_axi_arvalid;
      if (ssf_hit(s_axi_araddr, IDX_STATUS)) begin
         rd_data[7:0] = status_view;
      end else if (ssf_hit(s_axi_araddr, IDX_PRESS_HIGH)) begin
         rd_data[7:0] = st_ff.press_result_high;
         rd_press = rd_fire;
      end else if (ssf_hit(s_axi_araddr, IDX_TEMP_HIGH)) begin
         rd_data[7:0] = st_ff.temp_result_high;
         rd_temp = rd_fire;
      end else if (ssf_hit(s_axi_araddr, IDX_MAIN_CONTROL)) begin
         rd_data[CTRL_RUN_BIT] = st_ff.ctrl_run;
         rd_data[CTRL_HOLD_BIT] = st_ff.block_update_hold;
      end else if (ssf_hit(s_axi_araddr, IDX_IRQ_STATUS)) begin
         rd_data[IRQ_W-1:0] = st_ff.irq_stat;
         rd_irq = rd_fire;
      end else if (ssf_hit(s_axi_araddr, IDX_IRQ_MASK)) begin
         rd_data[IRQ_W-1:0] = st_ff.irq_mask;
      end else if (ssf_hit(s_axi_araddr, IDX_RATE_PERIOD)) begin
         rd_data[PERIOD_W-1:0] = st_ff.rate_period;
      end else begin
         rd_resp = RESP_SLVERR;
      end
   end

   // sample bookkeeping: commits happen only on the output rate pulse
   always_comb begin
      press_commit = output_rate_cycle & st_ff.press_pend; // RULE1
      temp_commit = output_rate_cycle & st_ff.temp_pend; // RULE1
      // overrun only when the previous ready was not cleared meanwhile
      press_ovr_set = press_commit & st_ff.press_ready_flag
                      & ~rd_press; // RULE4
      temp_ovr_set = temp_commit & st_ff.temp_ready_flag
                     & ~rd_temp; // RULE2
      irq_events = '0;
      irq_events[IRQ_PRESS_READY_BIT] = press_commit;
      irq_events[IRQ_TEMP_READY_BIT] = temp_commit;
      irq_events[IRQ_PRESS_OVR_BIT] = press_ovr_set;
      irq_events[IRQ_TEMP_OVR_BIT] = temp_ovr_set;
   end

   always_comb begin
      nxt_st = st_ff;
      wr_fire = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;

      // write address and data are taken in either order
      if (st_ff.awready & s_axi_awvalid) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (st_ff.wready & s_axi_wvalid) begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid & s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      if (wr_fire) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         if (ssf_hit(st_ff.awaddr, IDX_MAIN_CONTROL)) begin
            if (st_ff.wstrb[0]) begin
               nxt_st.ctrl_run = st_ff.wdata[CTRL_RUN_BIT];
               nxt_st.block_update_hold = st_ff.wdata[CTRL_HOLD_BIT];
            end
         end else if (ssf_hit(st_ff.awaddr, IDX_IRQ_MASK)) begin
            if (st_ff.wstrb[0]) begin
               nxt_st.irq_mask = st_ff.wdata[IRQ_W-1:0];
            end
         end else if (ssf_hit(st_ff.awaddr, IDX_RATE_PERIOD)) begin
            for (int b = 0; b < 3; b++) begin
               if (st_ff.wstrb[b]) begin
                  nxt_st.rate_period[b*8 +: 8] = st_ff.wdata[b*8 +: 8];
               end
            end
         end else if (ssf_hit(st_ff.awaddr, IDX_STATUS)) begin
            nxt_st.bresp = RESP_OKAY; // RULE9
         end else if (ssf_hit(st_ff.awaddr, IDX_PRESS_HIGH)
                      || ssf_hit(st_ff.awaddr, IDX_TEMP_HIGH)
                      || ssf_hit(st_ff.awaddr, IDX_IRQ_STATUS)) begin
            nxt_st.bresp = RESP_OKAY;
         end else begin
            nxt_st.bresp = RESP_SLVERR;
         end
      end

      // read channel
      if (st_ff.rvalid & s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_data;
         nxt_st.rresp = rd_resp;
      end

      // clears from result reads come first so that a set wins
      if (rd_press) begin
         nxt_st.press_ready_flag = 1'b0; // RULE6
         nxt_st.press_ovr = 1'b0; // RULE4
      end
      if (rd_temp) begin
         nxt_st.temp_ready_flag = 1'b0; // RULE5
         nxt_st.temp_ovr = 1'b0; // RULE3
      end

      // output rate cycle: publish pending samples, hold setting ignored
      if (press_commit) begin
         nxt_st.press_ready_flag = 1'b1; // RULE6
         nxt_st.press_result_high = st_ff.press_pend_high;
         nxt_st.press_pend = 1'b0;
      end
      if (temp_commit) begin
         nxt_st.temp_ready_flag = 1'b1; // RULE5
         nxt_st.temp_result_high = st_ff.temp_pend_high;
         nxt_st.temp_pend = 1'b0;
      end
      if (press_ovr_set) begin
         nxt_st.press_ovr = 1'b1; // RULE4
      end
      if (temp_ovr_set) begin
         nxt_st.temp_ovr = 1'b1; // RULE2
      end

      // a sample arriving now waits for the next rate pulse
      if (press_sample_valid) begin
         nxt_st.press_pend = 1'b1;
         nxt_st.press_pend_high = press_sample_high;
      end
      if (temp_sample_valid) begin
         nxt_st.temp_pend = 1'b1;
         nxt_st.temp_pend_high = temp_sample_high;
      end

      // sticky interrupt status: read clears, a new event wins
      if (rd_irq) begin
         nxt_st.irq_stat = '0;
      end
      nxt_st.irq_stat = nxt_st.irq_stat | irq_events;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

      // one write and one read outstanding at most
      nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
      nxt_st.wready = ~nxt_st.w_held & ~nxt_st.bvalid;
      nxt_st.arready = ~nxt_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.ctrl_run <= CTRL_RUN_RST;
         st_ff.block_update_hold <= CTRL_HOLD_RST;
         st_ff.rate_period <= RATE_PERIOD_RST;
         st_ff.irq_mask <= IRQ_MASK_RST;
         st_ff.press_result_high <= RESULT_RST;
         st_ff.temp_result_high <= RESULT_RST;
         st_ff.press_ready_flag <= STATUS_RST[STAT_PRESS_READY_BIT]; // RULE8
         st_ff.temp_ready_flag <= STATUS_RST[STAT_TEMP_READY_BIT]; // RULE7
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign irq = st_ff.irq;

endmodule : ssf_status

// ---- tb/ssf_checker.sv ----
// port-level assertions for the sample status flag block
`timescale 1ns/10ps
module ssf_checker import ssf_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic press_sample_valid,
   input wire logic temp_sample_valid,
   input wire logic irq
);
   logic [ADDR_W-1:0] ra_ff;
   logic [ADDR_W-1:0] wa_ff;
   logic [1:0] pc_ff;
   logic [1:0] tc_ff;
   logic st_rd;
   logic unm;
   // sample counts since reset saturate at three
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_ff <= 2'h0;
         tc_ff <= 2'h0;
      end else begin
         if (press_sample_valid && pc_ff != 2'h3) pc_ff <= pc_ff + 2'h1;
         if (temp_sample_valid && tc_ff != 2'h3) tc_ff <= tc_ff + 2'h1;
      end
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
   end
   assign st_rd = s_axi_rvalid && (ra_ff == {2'h0, IDX_STATUS, 2'h0});
   assign unm = (ra_ff[1:0] != 2'h0) || (ra_ff[11:10] != 2'h0) ||
      !(ra_ff[9:2] inside {IDX_MAIN_CONTROL, IDX_STATUS, IDX_PRESS_HIGH,
      IDX_TEMP_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_RATE_PERIOD});
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_resv;
      st_rd |-> s_axi_rdata[31:6] == 26'h0 && s_axi_rdata[3:2] == 2'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_unm;
      s_axi_rvalid && unm |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read answer");
   property p_stwr;
      s_axi_bvalid && wa_ff == {2'h0, IDX_STATUS, 2'h0} |->
         s_axi_bresp == RESP_OKAY;
   endproperty
   a_stwr: assert property (p_stwr) else $error("status write refused");
   property p_rst;
      $rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle");
   property p_pr;
      st_rd && s_axi_rdata[0] |-> pc_ff != 2'h0;
   endproperty
   a_pr: assert property (p_pr) else $error("press ready unprompted");
   property p_tr;
      st_rd && s_axi_rdata[1] |-> tc_ff != 2'h0;
   endproperty
   a_tr: assert property (p_tr) else $error("temp ready unprompted");
   property p_po;
      st_rd && s_axi_rdata[4] |-> pc_ff > 2'h1;
   endproperty
   a_po: assert property (p_po) else $error("press overrun early");
   property p_to;
      st_rd && s_axi_rdata[5] |-> tc_ff > 2'h1;
   endproperty
   a_to: assert property (p_to) else $error("temp overrun early");
   c_pr: cover property (st_rd && s_axi_rdata[0]);
   c_to: cover property (st_rd && s_axi_rdata[5]);
   c_unm: cover property (s_axi_rvalid && unm);
endmodule : ssf_checker
bind ssf_status ssf_checker chk (.*);

// ---- tb/tb_top.sv ----
// self-checking bench of the sample status flag block
`timescale 1ns/10ps
module tb_top import ssf_pkg::*; ;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [DATA_W-1:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic press_sample_valid = 1'h0, temp_sample_valid = 1'h0;
   logic [7:0] press_sample_high = 8'h00, temp_sample_high = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   int errors = 0, total_checks = 0, cyc = 0;
   ssf_status uut (.*);
   always #10 aclk = ~aclk;
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'h0, i, 2'h0};
   endfunction : ba
   // ready bit k, plus overrun bit o+k after a second sample
   function automatic logic [31:0] evt(input int k, input int n, input int o);
      evt = 32'h0;
      evt[k] = 1'h1;
      if (n > 1) evt[o+k] = 1'h1;
   endfunction : evt
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] i, input logic [31:0] v,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= ba(i);
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] i, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= ba(i);
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
   endtask : rd
   // one sample pulse, then long enough for a rate pulse to commit it
   task automatic smp(input int k, input logic [7:0] b);
      @(posedge aclk);
      if (k != 0) temp_sample_valid <= 1'h1;
      else press_sample_valid <= 1'h1;
      temp_sample_high <= b;
      press_sample_high <= b;
      @(posedge aclk);
      temp_sample_valid <= 1'h0;
      press_sample_valid <= 1'h0;
      repeat (14) @(posedge aclk);
   endtask : smp
   task automatic summarize;
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         summarize;
      end
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] m;
      logic [7:0] b;
      int k;
      int n;
      void'($urandom(32'hfe3d5f69));
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(IDX_STATUS, d, r);
      chk("status_reset", d, 32'h0);
      wr(IDX_RATE_PERIOD, 32'h8, r);
      // update hold set: flags must refresh regardless
      wr(IDX_MAIN_CONTROL, 32'h3, r);
      wr(IDX_STATUS, 32'hFF, r);
      chk("status_wr_resp", 32'(r), 32'(RESP_OKAY));
      rd(IDX_STATUS, d, r);
      chk("status_after_wr", d, 32'h0);
      rd(8'hFF, d, r);
      chk("unmapped_resp", 32'(r), 32'(RESP_SLVERR));
      chk("unmapped_data", d, 32'h0);
      rd(IDX_MAIN_CONTROL, d, r);
      chk("control_rb", d, 32'h3);
      rd(IDX_RATE_PERIOD, d, r);
      chk("period_rb", d, 32'h8);
      // cleared byte strobe: the mask write must not land
      s_axi_wstrb <= 4'h0;
      wr(IDX_IRQ_MASK, 32'hF, r);
      s_axi_wstrb <= 4'hF;
      rd(IDX_IRQ_MASK, d, r);
      chk("mask_no_strobe", d, 32'h0);
      // stopped rate: a sample stays pending until run returns
      wr(IDX_MAIN_CONTROL, 32'h0, r);
      smp(0, 8'h5A);
      rd(IDX_STATUS, d, r);
      chk("status_stopped", d, 32'h0);
      wr(IDX_MAIN_CONTROL, 32'h3, r);
      repeat (12) @(posedge aclk);
      rd(IDX_STATUS, d, r);
      chk("status_resumed", d, 32'h1);
      rd(IDX_PRESS_HIGH, d, r);
      chk("press_high", d, 32'h5A);
      rd(IDX_IRQ_STATUS, d, r);
      chk("irq_pending", d, 32'h1);
      for (int i = 0; i < 10; i++) begin
         k = (i < 2) ? i : int'($urandom_range(1, 0));
         n = (i < 2) ? 2 : int'($urandom_range(2, 1));
         m = (i == 2) ? 4'h0 : 4'hF;
         wr(IDX_IRQ_MASK, 32'(m), r);
         repeat (n) begin
            b = 8'($urandom);
            smp(k, b);
         end
         chk("irq_level", 32'(irq), 32'(m != 4'h0));
         rd(IDX_STATUS, d, r);
         chk("status_set", d, evt(k, n, 4));
         rd((k != 0) ? IDX_TEMP_HIGH : IDX_PRESS_HIGH, d, r);
         chk("result_high", d, 32'(b));
         rd(IDX_STATUS, d, r);
         chk("status_clr", d, 32'h0);
         rd(IDX_IRQ_STATUS, d, r);
         chk("irq_status", d, evt(k, n, 2));
         repeat (2) @(posedge aclk);
         chk("irq_clr", 32'(irq), 32'h0);
      end
      summarize;
   end
endmodule : tb_top
